// ===== fmc_pkg.sv
// constants shared by the fan monitor configuration register block
package fmc_pkg;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_NS    = 25;                 // 40 MHz system clock
   localparam int STEP_NS   = 22_760_000;         // 22.76 ms duration step
   localparam int REPORT_NS = 45_520_000;         // 45.52 ms report floor
   localparam int STEP_CYC  = STEP_NS / CLK_NS;   // cycles per step
   localparam logic [7:0] REPORT_STEPS = 8'(REPORT_NS / STEP_NS);

   // ---------------------------------------------------------------
   // register indices, byte address is four times the index
   // ---------------------------------------------------------------
   localparam logic [7:0] IDX_STATUS2  = 8'h42;
   localparam logic [7:0] IDX_DURATION = 8'h79;
   localparam logic [7:0] IDX_LIMIT    = 8'h7a;
   localparam logic [7:0] IDX_PULSE    = 8'h7b;
   localparam logic [7:0] IDX_CFG4     = 8'h7d;
   localparam logic [7:0] IDX_TEST1    = 8'h7e;
   localparam logic [7:0] IDX_TEST2    = 8'h7f;
   localparam logic [7:0] IDX_MASK2    = 8'h80;
   localparam logic [7:0] IDX_LOCK     = 8'h81;
   localparam int         IDX_SPAN_W   = 10;      // byte address bits decoded

   // ---------------------------------------------------------------
   // reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] LIMIT_RST = 8'h00;
   localparam logic [7:0] PULSE_RST = 8'h55;
   localparam logic [7:0] CFG4_RST  = 8'h00;
   localparam logic [7:0] TEST_RST  = 8'h00;
   localparam logic [7:0] MASK_RST  = 8'h00;

   // ---------------------------------------------------------------
   // field layout
   // ---------------------------------------------------------------
   localparam int         CFG4_ALERT_BIT = 0;
   localparam int         CFG4_THR_LSB   = 2;
   localparam logic [7:0] CFG4_WMASK     = 8'h0d;
   localparam int         STAT_ASSERT_BIT = 0;
   localparam int         STAT_OVER_BIT   = 5;
   localparam logic [7:0] STAT_WMASK      = 8'h21;
   localparam int         LOCK_BIT        = 0;

   // ---------------------------------------------------------------
   // bus answers
   // ---------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ===== fmc_thermal_override_input_timer.sv
// thermal override duration timer and overtime detector
`timescale 1ns/10ps
`default_nettype none

module fmc_thermal_override_input_timer
   import fmc_pkg::*;
#(
   parameter int STEP_CYCLES = STEP_CYC
) (
   // clock and reset
   input  wire logic       clk_sys,
   input  wire logic       sys_rst,
   // pin, active low
   input  wire logic       thermal_override_n,
   // limit from the register file
   input  wire logic [7:0] assert_limit_field,
   // results
   output logic      [7:0] assert_duration_count,
   output logic            assert_event,
   output logic            overtime_event
);

   localparam int CW = $clog2(STEP_CYCLES);

   if (STEP_CYCLES < 2) begin : g_chk
      $error("STEP_CYCLES must be at least 2");
   end

   typedef struct packed {
      logic          sync1;
      logic          sync2;
      logic          act;
      logic          seen;
      logic          fired;
      logic [CW-1:0] tick;
      logic [7:0]    steps;
      logic [7:0]    dur;
      logic          ev_assert;
      logic          ev_over;
   } fmc_timer_s;

   localparam fmc_timer_s TIMER_RST = '{sync1: 1'b1, sync2: 1'b1, default: '0};

   fmc_timer_s q;
   fmc_timer_s d;
   logic       active;
   logic       rise;
   logic       step_end;

   // ---------------------------------------------------------------
   // duration counting
   // ---------------------------------------------------------------
   assign active   = ~q.sync2;
   assign rise     = active & ~q.act;
   assign step_end = (q.tick == CW'(STEP_CYCLES - 1));

   // next state: sync, step count, overtime check
   always_comb begin
      d           = q;
      d.sync1     = thermal_override_n;
      d.sync2     = q.sync1;
      d.act       = active;
      d.ev_assert = rise;
      d.ev_over   = 1'b0;
      if (rise) begin
         d.tick  = '0;
         d.steps = 8'h00;
         d.fired = 1'b0;
         d.seen  = 1'b1;
      end else if (active) begin
         if (step_end) begin
            d.tick = '0;
            if (q.steps != 8'hff) begin
               d.steps = q.steps + 8'h01;
            end
         end else begin
            d.tick = q.tick + CW'(1);
         end
      end
      // one overtime event per assertion
      if (active && !d.fired &&
          (assert_limit_field == 8'h00 || d.steps > assert_limit_field)) begin
         d.fired   = 1'b1;
         d.ev_over = 1'b1;
      end
      // short assertions report only the seen flag
      d.dur = (d.steps >= REPORT_STEPS) ? d.steps : {7'h00, d.seen};
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= TIMER_RST;
      end else begin
         q <= d;
      end
   end

   assign assert_duration_count = q.dur;
   assign assert_event          = q.ev_assert;
   assign overtime_event        = q.ev_over;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   over_zero_a: assert property (
      rise && assert_limit_field == 8'h00 |=> q.ev_over)
      else $error("zero limit did not fire at once");

   over_gt_a: assert property (
      q.ev_over |-> ($past(assert_limit_field) == 8'h00 ||
                     q.steps > $past(assert_limit_field)))
      else $error("overtime fired without exceeding limit");

   step_tick_a: assert property (
      !$past(sys_rst) && $changed(q.steps) |-> $past(step_end) || $past(rise))
      else $error("step count moved off a step boundary");

   dur_floor_a: assert property (
      q.steps < REPORT_STEPS |-> q.dur[7:1] == 7'h00)
      else $error("duration shown before report floor");

endmodule
`default_nettype wire

// ===== fmc_regs.sv
// fan monitor configuration and limit registers behind an axi4-lite slave
`timescale 1ns/10ps
`default_nettype none

module fmc_regs
   import fmc_pkg::*;
#(
   parameter int ADDR_W      = 12,
   parameter int STEP_CYCLES = STEP_CYC
) (
   // clock and reset
   input  wire logic              clk_sys,
   input  wire logic              sys_rst,
   // axi4-lite write address
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   // axi4-lite write response
   output logic      [1:0]        s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // axi4-lite read address
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   // axi4-lite read data
   output logic      [31:0]       s_axi_rdata,
   output logic      [1:0]        s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // thermal override pin, active low
   input  wire logic              thermal_override_n,
   // shared alert / 2.5 v pin
   output logic                   alert_pin_out,
   output logic                   alert_pin_oe,
   output logic                   analog_25v_en,
   // settings to the measurement side
   output logic      [1:0]        two_wire_threshold_select,
   output logic      [7:0]        fan_pulse_count_select,
   // interrupt
   output logic                   irq
);

   if (ADDR_W < IDX_SPAN_W) begin : g_chk
      $error("ADDR_W too small for the register map");
   end

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic              awrdy;
      logic              wrdy;
      logic              aw_have;
      logic              w_have;
      logic [ADDR_W-1:0] awaddr;
      logic [7:0]        wdata;
      logic              wstb;
      logic              bvalid;
      logic [1:0]        bresp;
      logic              arrdy;
      logic              rvalid;
      logic [1:0]        rresp;
      logic [7:0]        rdata;
      logic [7:0]        limit;
      logic [7:0]        pulse;
      logic [7:0]        cfg4;
      logic [7:0]        mask;
      logic [7:0]        status;
      logic              lock;
      logic              irq;
      logic              alert_oe;
      logic              alert_out;
      logic              a25_en;
   } fmc_regs_s;

   localparam fmc_regs_s REGS_RST = '{
      limit:     LIMIT_RST,
      pulse:     PULSE_RST,
      cfg4:      CFG4_RST,
      mask:      MASK_RST,
      alert_out: 1'b1,
      a25_en:    1'b1,
      default:   '0
   };

   fmc_regs_s  q;
   fmc_regs_s  d;
   logic [7:0] duration;
   logic       ev_assert;
   logic       ev_over;
   logic       wr_go;
   logic [7:0] wr_idx;
   logic [7:0] rd_idx;
   logic       rd_go;
   logic       stat_clr;

   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // word index of a byte address
   function automatic logic [7:0] reg_idx(input logic [ADDR_W-1:0] a);
      logic [ADDR_W-1:0] s;
      s = a >> 2;
      return s[7:0];
   endfunction

   // address lands on a mapped register
   function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
      logic [7:0] i;
      logic       hit;
      i = reg_idx(a);
      unique case (i)
         IDX_STATUS2, IDX_DURATION, IDX_LIMIT, IDX_PULSE, IDX_CFG4,
         IDX_TEST1, IDX_TEST2, IDX_MASK2, IDX_LOCK: hit = 1'b1;
         default: hit = 1'b0;
      endcase
      return hit && ((a >> IDX_SPAN_W) == '0);
   endfunction

   // ---------------------------------------------------------------
   // duration timer
   // ---------------------------------------------------------------
   fmc_thermal_override_input_timer #(
      .STEP_CYCLES (STEP_CYCLES)
   ) u_timer (
      .clk_sys               (clk_sys),
      .sys_rst               (sys_rst),
      .thermal_override_n    (thermal_override_n),
      .assert_limit_field    (q.limit),
      .assert_duration_count (duration),
      .assert_event          (ev_assert),
      .overtime_event        (ev_over)
   );

   // ---------------------------------------------------------------
   // bus and register next state
   // ---------------------------------------------------------------
   assign wr_go    = q.aw_have && q.w_have && !q.bvalid;
   assign wr_idx   = reg_idx(q.awaddr);
   assign rd_go    = s_axi_arvalid && q.arrdy;
   assign rd_idx   = reg_idx(s_axi_araddr);
   assign stat_clr = rd_go && reg_hit(s_axi_araddr) && rd_idx == IDX_STATUS2;

   // one combinational pass over the whole state
   always_comb begin
      d = q;
      // write address and data are taken in either order
      if (s_axi_awvalid && q.awrdy) begin
         d.aw_have = 1'b1;
         d.awaddr  = s_axi_awaddr;
      end
      if (s_axi_wvalid && q.wrdy) begin
         d.w_have = 1'b1;
         d.wdata  = s_axi_wdata[7:0];
         d.wstb   = s_axi_wstrb[0];
      end
      if (q.bvalid && s_axi_bready) begin
         d.bvalid = 1'b0;
      end
      // register write once both halves are held
      if (wr_go) begin
         d.aw_have = 1'b0;
         d.w_have  = 1'b0;
         d.bvalid  = 1'b1;
         d.bresp   = reg_hit(q.awaddr) ? RESP_OKAY : RESP_SLVERR;
         if (q.wstb && reg_hit(q.awaddr)) begin
            unique case (wr_idx)
               IDX_LIMIT: d.limit = q.wdata;
               IDX_PULSE: d.pulse = q.wdata;
               IDX_CFG4: begin
                  if (!q.lock) begin
                     d.cfg4 = q.wdata & CFG4_WMASK;
                  end
               end
               IDX_MASK2: d.mask = q.wdata & STAT_WMASK;
               IDX_LOCK: begin
                  if (q.wdata[LOCK_BIT]) begin
                     d.lock = 1'b1;
                  end
               end
               // read-only registers drop the write
               default: d.lock = q.lock;
            endcase
         end
      end
      d.awrdy = !d.aw_have;
      d.wrdy  = !d.w_have;
      // read channel
      if (q.rvalid && s_axi_rready) begin
         d.rvalid = 1'b0;
      end
      if (rd_go) begin
         d.rvalid = 1'b1;
         d.rresp  = reg_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         d.rdata  = 8'h00;
         if (reg_hit(s_axi_araddr)) begin
            unique case (rd_idx)
               IDX_STATUS2:  d.rdata = q.status;
               IDX_DURATION: d.rdata = duration;
               IDX_LIMIT:    d.rdata = q.limit;
               IDX_PULSE:    d.rdata = q.pulse;
               IDX_CFG4:     d.rdata = q.cfg4;
               IDX_MASK2:    d.rdata = q.mask;
               IDX_LOCK:     d.rdata = {7'h00, q.lock};
               default:      d.rdata = TEST_RST;
            endcase
         end
      end
      d.arrdy = !d.rvalid;
      // sticky status, a read clears, a new event wins
      d.status = stat_clr ? 8'h00 : q.status;
      d.status[STAT_ASSERT_BIT] = d.status[STAT_ASSERT_BIT] | ev_assert;
      d.status[STAT_OVER_BIT]   = d.status[STAT_OVER_BIT] | ev_over;
      d.irq = |(d.status & ~d.mask);
      // shared pin pulls low only as alert output
      d.alert_oe  = d.cfg4[CFG4_ALERT_BIT] & d.irq;
      d.alert_out = ~d.irq;
      d.a25_en    = ~d.cfg4[CFG4_ALERT_BIT];
   end

   // state register
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         q <= REGS_RST;
      end else begin
         q <= d;
      end
   end

   // ---------------------------------------------------------------
   // outputs, all straight from the state register
   // ---------------------------------------------------------------
   assign s_axi_awready             = q.awrdy;
   assign s_axi_wready              = q.wrdy;
   assign s_axi_bresp               = q.bresp;
   assign s_axi_bvalid              = q.bvalid;
   assign s_axi_arready             = q.arrdy;
   assign s_axi_rdata               = {24'h000000, q.rdata};
   assign s_axi_rresp               = q.rresp;
   assign s_axi_rvalid              = q.rvalid;
   assign alert_pin_out             = q.alert_out;
   assign alert_pin_oe              = q.alert_oe;
   assign analog_25v_en             = q.a25_en;
   assign two_wire_threshold_select = q.cfg4[CFG4_THR_LSB +: 2];
   assign fan_pulse_count_select    = q.pulse;
   assign irq                       = q.irq;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   sequence wr_cfg4_s;
      wr_go && q.wstb && reg_hit(q.awaddr) && wr_idx == IDX_CFG4;
   endsequence

   sequence wr_limit_s;
      wr_go && q.wstb && reg_hit(q.awaddr) && wr_idx == IDX_LIMIT;
   endsequence

   bresp_hold_a: assert property (
      q.bvalid && !s_axi_bready |=> q.bvalid && $stable(q.bresp))
      else $error("write response dropped before bready");

   rdata_hold_a: assert property (
      q.rvalid && !s_axi_rready |=> q.rvalid && $stable(q.rdata))
      else $error("read data dropped before rready");

   limit_store_a: assert property (
      wr_limit_s |=> q.limit == $past(q.wdata) && q.bvalid)
      else $error("limit write not stored");

   cfg4_lock_a: assert property (
      q.lock ##0 wr_cfg4_s |=> $stable(q.cfg4))
      else $error("locked config four changed");

   pulse_reset_a: assert property (
      $fell(sys_rst) |-> fan_pulse_count_select == PULSE_RST)
      else $error("pulse fields not at reset value");

   over_status_a: assert property (
      ev_over |=> q.status[STAT_OVER_BIT] && (irq || q.mask[STAT_OVER_BIT]))
      else $error("overtime event lost");

   over_set_a: assert property (
      ev_over |=> q.status[STAT_OVER_BIT])
      else $error("overtime did not set status bit");

   alert_pin_a: assert property (
      q.irq && q.cfg4[CFG4_ALERT_BIT] |-> alert_pin_oe && !alert_pin_out && !analog_25v_en)
      else $error("alert pin not driven while selected");

   test_zero_a: assert property (
      rd_go && (rd_idx == IDX_TEST1 || rd_idx == IDX_TEST2) |=> q.rdata == 8'h00)
      else $error("test register read not zero");

   thr_follow_a: assert property (
      !q.lock ##0 wr_cfg4_s |=>
         two_wire_threshold_select == $past(q.wdata[CFG4_THR_LSB +: 2]) && q.cfg4[1] == 1'b0)
      else $error("threshold output or reserved bit wrong");

endmodule
`default_nettype wire

// ===== fmc_far_model.sv
// far side model: thermal sensor on the override pin and pulled-up alert wire
`timescale 1ns/10ps
`default_nettype none

module fmc_far_model (
   // clock
   input  wire logic clk_sys,
   // sensor request from the bench, high = overheated
   input  wire logic thermal_override_input_req,
   // shared pin as driven by the block
   input  wire logic alert_pin_out,
   input  wire logic alert_pin_oe,
   // resolved pin levels
   output var logic  thermal_override_n,
   output logic      alert_wire
);
   // override pin is active low and idles high
   initial thermal_override_n = 1'b1;
   always @(posedge clk_sys) begin
      thermal_override_n <= ~thermal_override_input_req;
   end

   // pull-up holds the wire high unless the block drives it
   assign alert_wire = alert_pin_oe ? alert_pin_out : 1'b1;
endmodule

`default_nettype wire

// ===== fmc_tb.sv
// self-checking bench for the fan monitor configuration registers
`timescale 1ns/10ps
`default_nettype none

module testbench;
   import fmc_pkg::*;
   // ------------------------------------------------------------
   // signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [11:0] awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic [3:0]  wstrb = '0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, thermal_override_input_req = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, thermal_override_input_n;
   logic        al_out, al_oe, an_en, irq, al_wire;
   logic [1:0]  bresp, rresp, thr;
   logic [7:0]  pulse;
   logic [7:0]  v;
   int          failures = 0, n_compared = 0;

   // 40 mhz clock
   always #12.5 clk_sys = ~clk_sys;

   fmc_regs #(.ADDR_W(12), .STEP_CYCLES(8)) u_dut (
      .clk_sys(clk_sys), .sys_rst(sys_rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .thermal_override_n(thermal_override_input_n), .alert_pin_out(al_out), .alert_pin_oe(al_oe),
      .analog_25v_en(an_en), .two_wire_threshold_select(thr),
      .fan_pulse_count_select(pulse), .irq(irq));

   fmc_far_model u_far (
      .clk_sys(clk_sys), .thermal_override_input_req(thermal_override_input_req), .alert_pin_out(al_out),
      .alert_pin_oe(al_oe), .thermal_override_n(thermal_override_input_n), .alert_wire(al_wire));

   // ------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // write one register, hold each channel until taken
   task automatic wr(input logic [7:0] idx, input logic [7:0] dat, input logic [3:0] st,
                     input logic [1:0] exp_resp);
      logic got;
      got = 1'b0;
      @(posedge clk_sys);
      awaddr  <= {2'b00, idx, 2'b00};
      wdata   <= {24'h000000, dat};
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            check({30'h0, bresp}, {30'h0, exp_resp});
            bready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask

   // read one register and compare data and response
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [1:0] er);
      logic got;
      got = 1'b0;
      @(posedge clk_sys);
      araddr  <= {2'b00, idx, 2'b00};
      arvalid <= 1'b1;
      rready  <= 1'b1;
      while (!got) begin
         @(posedge clk_sys);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            check(rdata, exp);
            check({30'h0, rresp}, {30'h0, er});
            rready <= 1'b0;
            got = 1'b1;
         end
      end
   endtask

   task automatic report_and_stop;
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // watchdog against a hung handshake
   initial begin
      repeat (5000) @(posedge clk_sys);
      failures++;
      report_and_stop();
   end

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      // reset values
      rd(IDX_LIMIT, 32'h0, RESP_OKAY);
      rd(IDX_PULSE, 32'h55, RESP_OKAY);
      check({24'h0, pulse}, 32'h55);
      rd(IDX_CFG4, 32'h0, RESP_OKAY);
      check({31'h0, an_en}, 32'h1);
      rd(IDX_TEST1, 32'h0, RESP_OKAY);
      rd(IDX_TEST2, 32'h0, RESP_OKAY);
      rd(IDX_STATUS2, 32'h0, RESP_OKAY);
      rd(8'h01, 32'h0, RESP_SLVERR);
      wr(8'h01, 8'hff, 4'h1, RESP_SLVERR);
      $display("test reset_and_map done");
      // full limit range and a write with lane 0 disabled
      wr(IDX_LIMIT, 8'hff, 4'h1, RESP_OKAY);
      wr(IDX_LIMIT, 8'h33, 4'h0, RESP_OKAY);
      rd(IDX_LIMIT, 32'hff, RESP_OKAY);
      // every pulse count code on every fan
      for (int i = 0; i < 4; i++) begin
         v = {4{i[1:0]}};
         wr(IDX_PULSE, v, 4'h1, RESP_OKAY);
         rd(IDX_PULSE, {24'h0, v}, RESP_OKAY);
         check({24'h0, pulse}, {24'h0, v});
      end
      // every threshold code, both pin functions, reserved bits read zero
      for (int i = 0; i < 4; i++) begin
         v = {4'hf, i[1:0], 1'b1, i[0]};
         wr(IDX_CFG4, v, 4'h1, RESP_OKAY);
         rd(IDX_CFG4, {28'h0, i[1:0], 1'b0, i[0]}, RESP_OKAY);
         check({30'h0, thr}, {30'h0, i[1:0]});
         check({31'h0, an_en}, {31'h0, ~i[0]});
      end
      $display("test fields done");
      // zero limit: interrupt at once on assertion
      wr(IDX_LIMIT, 8'h00, 4'h1, RESP_OKAY);
      wr(IDX_CFG4, 8'h01, 4'h1, RESP_OKAY);
      check({31'h0, al_wire}, 32'h1);
      thermal_override_input_req <= 1'b1;
      repeat (8) @(posedge clk_sys);
      check({31'h0, irq}, 32'h1);
      check({31'h0, al_wire}, 32'h0);
      rd(IDX_STATUS2, 32'h21, RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      check({31'h0, irq}, 32'h0);
      thermal_override_input_req <= 1'b0;
      repeat (4) @(posedge clk_sys);
      $display("test zero_limit done");
      // limit of two steps: no flag at equal count, flag once above
      wr(IDX_LIMIT, 8'h02, 4'h1, RESP_OKAY);
      thermal_override_input_req <= 1'b1;
      repeat (6) @(posedge clk_sys);
      rd(IDX_DURATION, 32'h01, RESP_OKAY);
      // status read lands while the step count equals the limit
      repeat (14) @(posedge clk_sys);
      rd(IDX_STATUS2, 32'h01, RESP_OKAY);
      repeat (20) @(posedge clk_sys);
      check({31'h0, irq}, 32'h1);
      wr(IDX_MASK2, 8'h20, 4'h1, RESP_OKAY);
      repeat (2) @(posedge clk_sys);
      check({31'h0, irq}, 32'h0);
      rd(IDX_STATUS2, 32'h20, RESP_OKAY);
      wr(IDX_MASK2, 8'h00, 4'h1, RESP_OKAY);
      thermal_override_input_req <= 1'b0;
      $display("test overtime done");
      // lock freezes configuration four
      wr(IDX_CFG4, 8'h05, 4'h1, RESP_OKAY);
      wr(IDX_LOCK, 8'h01, 4'h1, RESP_OKAY);
      rd(IDX_LOCK, 32'h01, RESP_OKAY);
      wr(IDX_CFG4, 8'h08, 4'h1, RESP_OKAY);
      rd(IDX_CFG4, 32'h05, RESP_OKAY);
      check({30'h0, thr}, 32'h1);
      $display("test lock done");
      report_and_stop();
   end
endmodule

`default_nettype wire
